/* logic/rssf_map.svh */
// Notes on behaviour
// - flags latch high until register read
// - read clears only if fault gone
// - power-on reset zeroes all bits
// - dedicated read commands only, writes ignored
// - prereg fault bits 7-6 zero, bit5 eovp
// - prereg fault bit4 ground loss
// - prereg fault bit3 overvoltage protect
// - prereg fault bit2 lowside sink limit
// - prereg fault bit1 overload
// - prereg fault bit0 short to ground
// - prereg thermal bits 7-2 zero, bit1 shutdown
// - prereg thermal bit0 warning
// - lowvolt fault bits 7-5 zero, bit4 ground
// - lowvolt fault bit3 overvoltage protect
// - lowvolt fault bit2 lowside sink limit
// - lowvolt fault bit1 overload
// - lowvolt fault bit0 short to ground
// - flags active high, one means fault
// - lowvolt thermal bit1 shutdown, bit0 warning
`ifndef RSSF_MAP_SVH
`define RSSF_MAP_SVH
`define RSSF_RESET_VALUE   8'h00
`define RSSF_PREREG_FAULT_MASK  8'h3f
`define RSSF_PREREG_THERM_MASK  8'h03
`define RSSF_LOWVOLT_FAULT_MASK 8'h1f
`define RSSF_LOWVOLT_THERM_MASK 8'h03
`define RSSF_BIT_EOVP      5
`define RSSF_BIT_GND_LOSS  4
`define RSSF_BIT_OVP       3
`define RSSF_BIT_SINK      2
`define RSSF_BIT_OVERLOAD  1
`define RSSF_BIT_SCG       0
`define RSSF_BIT_OT_STD    1
`define RSSF_BIT_OT_WARN   0
`define RSSF_READ_LATENCY  1
`endif

/* logic/rssf_pkg.sv */
package rssf_pkg;
   typedef struct packed {
      logic extreme_overvoltage;
      logic ground_loss;
      logic overvoltage_protect;
      logic lowside_sink_limit;
      logic overload;
      logic short_to_ground;
   } rssf_fault_type;
   typedef struct packed {
      logic thermal_shutdown;
      logic thermal_warning;
   } rssf_therm_type;
   typedef enum logic [3:0] {
      RSSF_SEL_PREREG_FAULT   = 4'h1,
      RSSF_SEL_PREREG_THERM   = 4'h2,
      RSSF_SEL_LOWVOLT_FAULT  = 4'h4,
      RSSF_SEL_LOWVOLT_THERM  = 4'h8
   } rssf_sel_type;
   typedef enum logic [1:0] {
      RSSF_IDLE = 2'h1,
      RSSF_ANSW = 2'h2
   } rssf_state_type;
endpackage

/* logic/rssf_flag_reg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rssf_map.svh"
module rssf_flag_reg
   import rssf_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hff
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       reset_i,
   // fault conditions and read strobe
   input  wire logic [7:0] cond_i,
   input  wire logic       rd_i,
   // latched flags
   output var  logic [7:0] flags_o
);
   wire logic [7:0] live = cond_i & MASK;
   // set wins over clear; a read drops only bits whose fault is gone
   wire logic [7:0] next_flags = rd_i ? live : ((flags_o | live) & MASK);
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flags_o <= `RSSF_RESET_VALUE;
      end else begin
         flags_o <= next_flags;
      end
   end
   chk_latch_holds: assert property (@(posedge clk_i) disable iff (reset_i)
      (!rd_i && flags_o[0]) |=> flags_o[0]) else $error("flag dropped without read");
   chk_read_keeps: assert property (@(posedge clk_i) disable iff (reset_i)
      (rd_i && live[0]) |=> flags_o[0]) else $error("flag lost under persisting fault");
   chk_read_clears: assert property (@(posedge clk_i) disable iff (reset_i)
      (rd_i && !live[0]) |=> !flags_o[0]) else $error("flag not cleared by read");
   chk_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      (flags_o & ~MASK) == 8'h00) else $error("reserved bit set");
endmodule
`default_nettype wire

/* logic/rssf_cmd_dec.sv */
`timescale 1ns/1ps
`default_nettype none
module rssf_cmd_dec
   import rssf_pkg::*;
(
   // command
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_write_i,
   input  wire logic [3:0] cmd_sel_i,
   // decoded read strobes
   output logic [3:0]      rd_o
);
   // writes never reach the flags
   wire logic take = cmd_valid_i && !cmd_write_i;
   assign rd_o = take ? cmd_sel_i & {4{cmd_sel_i == RSSF_SEL_PREREG_FAULT
                                  || cmd_sel_i == RSSF_SEL_PREREG_THERM
                                  || cmd_sel_i == RSSF_SEL_LOWVOLT_FAULT
                                  || cmd_sel_i == RSSF_SEL_LOWVOLT_THERM}} : 4'h0;
endmodule
`default_nettype wire

/* logic/rssf_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "rssf_map.svh"
module rssf_top
   import rssf_pkg::*;
(
   // clock and reset
   input  wire logic           clk_i,
   input  wire logic           reset_i,
   // analog monitor fault conditions, active high
   input  wire rssf_fault_type prereg_fault_i,
   input  wire rssf_therm_type prereg_therm_i,
   input  wire rssf_fault_type lowvolt_fault_i,
   input  wire rssf_therm_type lowvolt_therm_i,
   // serial command: one-hot register select, write attempts ignored
   input  wire logic           cmd_valid_i,
   input  wire logic           cmd_write_i,
   input  wire logic [3:0]     cmd_sel_i,
   // read answer
   output logic                rd_valid_o,
   output logic [7:0]          rd_data_o,
   // live flag view
   output var rssf_fault_type  prereg_flags_o,
   output var rssf_fault_type  lowvolt_flags_o
);
   wire logic [3:0] rd;
   wire logic [7:0] pf_q;
   wire logic [7:0] pt_q;
   wire logic [7:0] lf_q;
   wire logic [7:0] lt_q;
   wire logic [7:0] pf_c = {2'b00, prereg_fault_i};
   wire logic [7:0] pt_c = {6'b000000, prereg_therm_i};
   // lowvolt layout has no extreme overvoltage bit
   wire logic [7:0] lf_c = {3'b000, lowvolt_fault_i.ground_loss,
                            lowvolt_fault_i.overvoltage_protect,
                            lowvolt_fault_i.lowside_sink_limit,
                            lowvolt_fault_i.overload,
                            lowvolt_fault_i.short_to_ground};
   wire logic [7:0] lt_c = {6'b000000, lowvolt_therm_i};

   rssf_cmd_dec u_dec (
      .cmd_valid_i (cmd_valid_i),
      .cmd_write_i (cmd_write_i),
      .cmd_sel_i   (cmd_sel_i),
      .rd_o        (rd)
   );
   rssf_flag_reg #(.MASK(`RSSF_PREREG_FAULT_MASK)) u_pf (
      .clk_i (clk_i), .reset_i (reset_i), .cond_i (pf_c), .rd_i (rd[0]), .flags_o (pf_q));
   rssf_flag_reg #(.MASK(`RSSF_PREREG_THERM_MASK)) u_pt (
      .clk_i (clk_i), .reset_i (reset_i), .cond_i (pt_c), .rd_i (rd[1]), .flags_o (pt_q));
   rssf_flag_reg #(.MASK(`RSSF_LOWVOLT_FAULT_MASK)) u_lf (
      .clk_i (clk_i), .reset_i (reset_i), .cond_i (lf_c), .rd_i (rd[2]), .flags_o (lf_q));
   rssf_flag_reg #(.MASK(`RSSF_LOWVOLT_THERM_MASK)) u_lt (
      .clk_i (clk_i), .reset_i (reset_i), .cond_i (lt_c), .rd_i (rd[3]), .flags_o (lt_q));

   // answer carries the value held before the clearing read
   wire logic [7:0] next_data = rd[0] ? pf_q : rd[1] ? pt_q : rd[2] ? lf_q :
                                rd[3] ? lt_q : 8'h00;
   wire logic       next_valid = |rd;
   rssf_fault_type  lv_view;
   assign lv_view = {1'b0, lf_q[4:0]};

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rd_valid_o      <= 1'b0;
         rd_data_o       <= `RSSF_RESET_VALUE;
         prereg_flags_o  <= '0;
         lowvolt_flags_o <= '0;
      end else begin
         rd_valid_o      <= next_valid;
         rd_data_o       <= next_data;
         prereg_flags_o  <= pf_q[5:0];
         lowvolt_flags_o <= lv_view;
      end
   end

   chk_write_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
      (cmd_valid_i && cmd_write_i) |=> !rd_valid_o) else $error("write answered");
   chk_answer_data: assert property (@(posedge clk_i) disable iff (reset_i)
      rd[0] |=> (rd_valid_o && rd_data_o == $past(pf_q))) else $error("bad read data");
   chk_fault_sets: assert property (@(posedge clk_i) disable iff (reset_i)
      prereg_fault_i.short_to_ground |=> pf_q[`RSSF_BIT_SCG]) else $error("fault not latched");
   chk_set_wins: assert property (@(posedge clk_i) disable iff (reset_i)
      (rd[3] && lowvolt_therm_i.thermal_warning) |=> lt_q[`RSSF_BIT_OT_WARN])
      else $error("event lost on read");
   chk_reset_zero: assert property (@(posedge clk_i)
      reset_i |=> (pf_q == 8'h00 && rd_data_o == 8'h00)) else $error("reset not zero");
   chk_lv_top_zero: assert property (@(posedge clk_i) disable iff (reset_i)
      lf_q[7:5] == 3'b000) else $error("lowvolt reserved set");
   cov_read_clear: cover property (@(posedge clk_i) pf_q[0] ##1 rd[0] ##1 !pf_q[0]);
   cov_read_keep: cover property (@(posedge clk_i) rd[1] && pt_c[1] ##1 pt_q[1]);
   cov_write_try: cover property (@(posedge clk_i) cmd_valid_i && cmd_write_i);
endmodule
`default_nettype wire

/* testbench/rssf_host.sv */
`timescale 1ns/1ps
`default_nettype none
module rssf_host (
   // clock
   input  wire logic       clk_i,
   // answer from the flag bank
   input  wire logic       rd_valid_i,
   input  wire logic [7:0] rd_data_i,
   // command to the flag bank
   output logic            cmd_valid_o,
   output logic            cmd_write_o,
   output logic [3:0]      cmd_sel_o
);
   initial begin
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_sel_o   = 4'h0;
   end
   // one command per call; confirming a clear takes a second call
   task automatic access(input logic wr, input logic [3:0] sel,
                         output logic vld, output logic [7:0] data);
      @(posedge clk_i);
      #2;
      cmd_valid_o = 1'b1;
      cmd_write_o = wr;
      cmd_sel_o   = sel;
      @(posedge clk_i);
      #2;
      vld         = rd_valid_i;
      data        = rd_data_i;
      cmd_valid_o = 1'b0;
      cmd_write_o = 1'b0;
      cmd_sel_o   = 4'h0;
   endtask
endmodule
`default_nettype wire

/* testbench/regulator_safety_status_flags_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module regulator_safety_status_flags_bench;
   import rssf_pkg::*;
   typedef struct packed {
      logic [3:0] sel;
      logic [5:0] cond;
      logic [7:0] exp;
   } rssf_row_type;
   logic           clk_i;
   logic           reset_i = 1'b1;
   rssf_fault_type pf = '0;
   rssf_fault_type lf = '0;
   rssf_therm_type pt = '0;
   rssf_therm_type lt = '0;
   logic           cv, cw, rv, v;
   logic [3:0]     cs;
   logic [7:0]     rd, d;
   rssf_fault_type pfo, lfo;
   int             errors = 0;
   int             tests_run = 0;
   // all-ones rows show the reserved bits stay low
   rssf_row_type   rows [8] = '{'{4'h1, 6'h3f, 8'h3f}, '{4'h2, 6'h3f, 8'h03},
      '{4'h4, 6'h3f, 8'h1f}, '{4'h8, 6'h3f, 8'h03}, '{4'h1, 6'h15, 8'h15},
      '{4'h4, 6'h2a, 8'h0a}, '{4'h2, 6'h01, 8'h01}, '{4'h8, 6'h02, 8'h02}};
   rssf_top i_dut (.clk_i(clk_i), .reset_i(reset_i), .prereg_fault_i(pf),
      .prereg_therm_i(pt), .lowvolt_fault_i(lf), .lowvolt_therm_i(lt),
      .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_sel_i(cs), .rd_valid_o(rv),
      .rd_data_o(rd), .prereg_flags_o(pfo), .lowvolt_flags_o(lfo));
   rssf_host i_host (.clk_i(clk_i), .rd_valid_i(rv), .rd_data_i(rd),
      .cmd_valid_o(cv), .cmd_write_o(cw), .cmd_sel_o(cs));
   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic rdchk(input logic [3:0] sel, input logic [7:0] exp);
      i_host.access(1'b0, sel, v, d);
      check({7'h00, v}, 8'h01);
      check(d, exp);
   endtask
   task automatic drive(input logic [3:0] sel, input logic [5:0] c);
      @(posedge clk_i);
      #2;
      pf = rssf_fault_type'(sel == 4'h1 ? c : 6'h00);
      pt = rssf_therm_type'(sel == 4'h2 ? c[1:0] : 2'h0);
      lf = rssf_fault_type'(sel == 4'h4 ? c : 6'h00);
      lt = rssf_therm_type'(sel == 4'h8 ? c[1:0] : 2'h0);
   endtask
   task automatic print_verdict;
      $display("comparisons %0d, mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge clk_i);
      #2 reset_i = 1'b0;
      for (int i = 0; i < 4; i++) rdchk(4'h1 << i, 8'h00);
      foreach (rows[i]) begin
         drive(rows[i].sel, rows[i].cond);
         drive(rows[i].sel, 6'h00);
         rdchk(rows[i].sel, rows[i].exp);
         rdchk(rows[i].sel, 8'h00);
      end
      // a fault that outlives the read must survive it
      drive(4'h1, 6'h02);
      rdchk(4'h1, 8'h02);
      rdchk(4'h1, 8'h02);
      check({2'b00, pfo}, 8'h02);
      drive(4'h1, 6'h00);
      rdchk(4'h1, 8'h02);
      rdchk(4'h1, 8'h00);
      drive(4'h4, 6'h01);
      drive(4'h4, 6'h00);
      @(posedge clk_i);
      #2;
      check({2'b00, lfo}, 8'h01);
      i_host.access(1'b1, 4'h4, v, d);
      check({7'h00, v}, 8'h00);
      i_host.access(1'b0, 4'h3, v, d);
      check({7'h00, v}, 8'h00);
      rdchk(4'h4, 8'h01);
      rdchk(4'h4, 8'h00);
      // new warning lands in the very cycle of the clearing read
      drive(4'h8, 6'h02);
      drive(4'h8, 6'h00);
      fork
         rdchk(4'h8, 8'h02);
         begin
            @(posedge clk_i);
            #2 lt = 2'b01;
            @(posedge clk_i);
            #2 lt = 2'b00;
         end
      join
      rdchk(4'h8, 8'h01);
      rdchk(4'h8, 8'h00);
      drive(4'h2, 6'h03);
      drive(4'h2, 6'h00);
      @(posedge clk_i);
      #2 reset_i = 1'b1;
      repeat (2) @(posedge clk_i);
      #2 reset_i = 1'b0;
      rdchk(4'h2, 8'h00);
      print_verdict();
   end
endmodule
`default_nettype wire
